// file: core/gpabc_ports.sv
// Purpose: Data latches, direction registers and pin muxing for ports A, B, C
// Assumes: Module control fields arrive from on-chip logic on clk
// Notes:   Pin inputs are synchronised before any read path sees them
// What this block does
// - Direction bit 1 enables pin output buffer; 0 leaves pin high-impedance input.
// - Reset clears all direction bits, every pin starts as input.
// - Reset leaves the data latches untouched.
// - Port A data read gives latch for outputs, pin level for inputs.
// - Port B data read gives pin level for inputs, latch for outputs.
// - Port C data read gives latch for outputs, pin level for inputs.
// - Data writes always update latch; input read-back stays the pin.
// - ADC channel selecting a port B pin overrides its port logic.
// - First timer edge/level fields claim port B pins 2 and 3.
// - Second timer edge/level fields claim port B pins 4 and 5.
// - Port B pin 2 feeds periodic-interrupt clock when source field is 01.
// - LCD module enable hands port B pins 6 and 7 to frontplanes.
// - High-drive bits select high sink drive on port B pins 2 to 5.
// - High drive acts only where the pin is an output.
// - Port C upper/lower enables with LCD enable hand pins to frontplanes.
// - Enabled keyboard inputs override port A pin logic.
`timescale 1ns/1ps
`default_nettype none

module gpabc_ports
    import gpabc_pkg::*;
(
    input  wire logic                  clk,              // 50 MHz system clock
    input  wire logic                  sys_rst,          // Synchronous reset, high
    input  wire gpabc_bus_req_type     bus_req,          // Register access request
    output var  logic [7:0]            bus_rdata,        // Read data, cycle after read
    input  wire gpabc_module_ctrl_type mod_ctrl,         // Shared-function controls
    input  wire logic [7:0]            port_a_in,        // Port A pin levels
    input  wire logic [7:0]            port_b_in,        // Port B pin levels
    input  wire logic [7:0]            port_c_in,        // Port C pin levels
    input  wire logic                  periodic_irq_pending, // Pending flag, periodic unit
    input  wire gpabc_pin_drive_type   timer_drive,      // Timer pins, bits 5:2 used
    input  wire gpabc_pin_drive_type   lcd_drive_b,      // Frontplane drive, bits 7:6
    input  wire gpabc_pin_drive_type   lcd_drive_c,      // Frontplane drive, bits 5:0
    output var  gpabc_pin_drive_type   port_a_pins,      // Port A out and enable
    output var  gpabc_pin_drive_type   port_b_pins,      // Port B out and enable
    output var  gpabc_pin_drive_type   port_c_pins,      // Port C out and enable
    output var  logic [7:0]            port_b_high_sink, // High sink drive per pin
    output var  logic [7:0]            port_b_analog,    // Pin given to ADC
    output var  logic [7:0]            timer_capture_in, // Synced pins for timers
    output var  logic                  periodic_irq_external_clock, // Synced clock in
    output var  logic [3:0]            keyboard_interrupt_input,    // Synced key pins
    output var  logic [1:0]            periodic_irq_clock_source    // Clock source field
);

    // ------------------------------------------------------------
    // Registers and combinational nets
    // ------------------------------------------------------------
    logic [7:0] port_a_data_latch_q;
    logic [7:0] port_b_data_latch_q;
    logic [7:0] port_c_data_latch_q;
    logic [7:0] port_a_direction_q;
    logic [7:0] port_b_direction_q;
    logic [7:0] port_c_direction_q;
    logic [7:0] port_b_high_drive_control_q;
    logic [7:0] sync_a_s1_q;
    logic [7:0] sync_a_q;
    logic [7:0] sync_b_s1_q;
    logic [7:0] sync_b_q;
    logic [7:0] sync_c_s1_q;
    logic [7:0] sync_c_q;
    logic [7:0] rdata_d;
    logic [7:0] b_override;
    logic [7:0] c_override;
    logic [7:0] a_override;
    logic [7:0] b_adc_sel;
    logic [7:0] b_timer_sel;
    logic [7:0] b_lcd_sel;
    logic [7:0] c_lcd_sel;
    logic [7:0] hd_read;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        sync_a_s1_q <= port_a_in;
        sync_a_q    <= sync_a_s1_q;
        sync_b_s1_q <= port_b_in;
        sync_b_q    <= sync_b_s1_q;
        sync_c_s1_q <= port_c_in;
        sync_c_q    <= sync_c_s1_q;
    end

    // ------------------------------------------------------------
    // Data latches, no reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                GPABC_ADDR_PORT_A_DATA: port_a_data_latch_q <= bus_req.wdata;
                GPABC_ADDR_PORT_B_DATA: port_b_data_latch_q <= bus_req.wdata;
                GPABC_ADDR_PORT_C_DATA: port_c_data_latch_q <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Direction and high-drive registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_a_direction_q <= GPABC_DIR_RESET;
            port_b_direction_q <= GPABC_DIR_RESET;
            port_c_direction_q <= GPABC_DIR_RESET;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                GPABC_ADDR_PORT_A_DIR: port_a_direction_q <= bus_req.wdata;
                GPABC_ADDR_PORT_B_DIR: port_b_direction_q <= bus_req.wdata;
                GPABC_ADDR_PORT_C_DIR: port_c_direction_q <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_b_high_drive_control_q <= GPABC_HD_RESET;
        end else if (bus_req.wr && bus_req.addr == GPABC_ADDR_HIGH_DRIVE) begin
            port_b_high_drive_control_q <= bus_req.wdata
                                         & (GPABC_HD_DRIVE_MASK | GPABC_HD_CLKS_MASK);
        end
    end

    // ------------------------------------------------------------
    // Shared-function selection
    // ------------------------------------------------------------
    always_comb begin
        b_adc_sel    = 8'h00;
        b_adc_sel[0] = mod_ctrl.adc_enable
                     && mod_ctrl.analog_channel_select == GPABC_ADC_CH_PB0;
        b_adc_sel[1] = mod_ctrl.adc_enable
                     && mod_ctrl.analog_channel_select == GPABC_ADC_CH_PB1;
        b_timer_sel    = 8'h00;
        b_timer_sel[2] = |mod_ctrl.timer1_ch0_edge_level_select;
        b_timer_sel[3] = |mod_ctrl.timer1_ch1_edge_level_select;
        b_timer_sel[4] = |mod_ctrl.timer2_ch0_edge_level_select;
        b_timer_sel[5] = |mod_ctrl.timer2_ch1_edge_level_select;
        b_lcd_sel    = {{2{mod_ctrl.lcd_module_enable}}, 6'h00};
        c_lcd_sel    = ({8{mod_ctrl.lcd_module_enable && mod_ctrl.portc_upper_lcd_enable}}
                        & GPABC_PC_UPPER_MASK)
                     | ({8{mod_ctrl.lcd_module_enable && mod_ctrl.portc_lower_lcd_enable}}
                        & GPABC_PC_LOWER_MASK);
        b_override   = b_adc_sel | b_timer_sel | b_lcd_sel;
        c_override   = c_lcd_sel;
        a_override   = {4'h0, mod_ctrl.keyboard_interrupt_enable};
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_a_pins      <= '0;
            port_b_pins      <= '0;
            port_c_pins      <= '0;
            port_b_high_sink <= 8'h00;
            port_b_analog    <= 8'h00;
        end else begin
            port_a_pins.out  <= port_a_data_latch_q;
            port_a_pins.oe   <= port_a_direction_q & ~a_override;
            port_b_pins.out  <= (port_b_data_latch_q & ~b_override)
                              | (timer_drive.out & b_timer_sel)
                              | (lcd_drive_b.out & b_lcd_sel);
            port_b_pins.oe   <= (port_b_direction_q & ~b_override)
                              | (timer_drive.oe & b_timer_sel & ~b_adc_sel)
                              | (lcd_drive_b.oe & b_lcd_sel);
            port_c_pins.out  <= (port_c_data_latch_q & ~c_override)
                              | (lcd_drive_c.out & c_override);
            port_c_pins.oe   <= (port_c_direction_q & ~c_override)
                              | (lcd_drive_c.oe & c_override);
            port_b_high_sink <= port_b_high_drive_control_q & GPABC_HD_DRIVE_MASK
                              & port_b_direction_q & ~b_override;
            port_b_analog    <= b_adc_sel;
        end
    end

    // ------------------------------------------------------------
    // Inputs handed to other modules
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_capture_in            <= 8'h00;
            periodic_irq_external_clock <= 1'b0;
            keyboard_interrupt_input    <= 4'h0;
            periodic_irq_clock_source   <= 2'h0;
        end else begin
            timer_capture_in            <= sync_b_q & b_timer_sel;
            periodic_irq_external_clock <= sync_b_q[2]
                && port_b_high_drive_control_q[1:0] == GPABC_CLKS_EXTERNAL;
            keyboard_interrupt_input    <= sync_a_q[3:0] & mod_ctrl.keyboard_interrupt_enable;
            periodic_irq_clock_source   <= port_b_high_drive_control_q[1:0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        hd_read                       = port_b_high_drive_control_q;
        hd_read[GPABC_HD_PENDING_BIT] = periodic_irq_pending;
        unique case (bus_req.addr)
            GPABC_ADDR_PORT_A_DATA: rdata_d = (port_a_data_latch_q & port_a_direction_q)
                                            | (sync_a_q & ~port_a_direction_q);
            GPABC_ADDR_PORT_B_DATA: rdata_d = (sync_b_q & ~port_b_direction_q)
                                            | (port_b_data_latch_q & port_b_direction_q);
            GPABC_ADDR_PORT_C_DATA: rdata_d = (port_c_data_latch_q & port_c_direction_q)
                                            | (sync_c_q & ~port_c_direction_q);
            GPABC_ADDR_PORT_A_DIR:  rdata_d = port_a_direction_q;
            GPABC_ADDR_PORT_B_DIR:  rdata_d = port_b_direction_q;
            GPABC_ADDR_PORT_C_DIR:  rdata_d = port_c_direction_q;
            GPABC_ADDR_HIGH_DRIVE:  rdata_d = hd_read;
            default:                rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            bus_rdata <= rdata_d;
        end else begin
            bus_rdata <= 8'h00;
        end
    end

endmodule : gpabc_ports

`default_nettype wire

// file: core/gpabc_pkg.sv
// Purpose: Constants and types for the port A/B/C general-purpose I/O block
// Assumes: 8-bit register port, one aligned register per address
// Notes:   Direction and high-drive offsets are local choices
package gpabc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] GPABC_ADDR_PORT_A_DATA  = 8'h00;
    localparam logic [7:0] GPABC_ADDR_PORT_B_DATA  = 8'h01;
    localparam logic [7:0] GPABC_ADDR_PORT_C_DATA  = 8'h02;
    localparam logic [7:0] GPABC_ADDR_PORT_A_DIR   = 8'h04;
    localparam logic [7:0] GPABC_ADDR_PORT_B_DIR   = 8'h05;
    localparam logic [7:0] GPABC_ADDR_PORT_C_DIR   = 8'h06;
    localparam logic [7:0] GPABC_ADDR_HIGH_DRIVE   = 8'h0C;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] GPABC_DIR_RESET         = 8'h00;
    localparam logic [7:0] GPABC_HD_RESET          = 8'h00;
    localparam logic [7:0] GPABC_HD_DRIVE_MASK     = 8'h3C;
    localparam logic [7:0] GPABC_HD_CLKS_MASK      = 8'h03;
    localparam int         GPABC_HD_PENDING_BIT    = 7;
    localparam logic [1:0] GPABC_CLKS_EXTERNAL     = 2'h1;
    localparam logic [4:0] GPABC_ADC_CH_PB0        = 5'h04;
    localparam logic [4:0] GPABC_ADC_CH_PB1        = 5'h05;
    localparam logic [7:0] GPABC_PC_UPPER_MASK     = 8'h30;
    localparam logic [7:0] GPABC_PC_LOWER_MASK     = 8'h0F;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gpabc_bus_req_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gpabc_pin_drive_type;

    typedef struct packed {
        logic       adc_enable;
        logic [4:0] analog_channel_select;
        logic [1:0] timer1_ch0_edge_level_select;
        logic [1:0] timer1_ch1_edge_level_select;
        logic [1:0] timer2_ch0_edge_level_select;
        logic [1:0] timer2_ch1_edge_level_select;
        logic       lcd_module_enable;
        logic       portc_upper_lcd_enable;
        logic       portc_lower_lcd_enable;
        logic [3:0] keyboard_interrupt_enable;
    } gpabc_module_ctrl_type;

endpackage : gpabc_pkg

// file: test/gpabc_ports_sva.sv
// Purpose: Port-level assertions for gpabc_ports
// Assumes: Sees only the top module ports
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module gpabc_ports_sva
    import gpabc_pkg::*;
(
    input wire logic                  clk,                         // Clock
    input wire logic                  sys_rst,                     // Reset
    input wire gpabc_bus_req_type     bus_req,                     // Request
    input wire logic [7:0]            bus_rdata,                   // Read data
    input wire gpabc_module_ctrl_type mod_ctrl,                    // Controls
    input wire logic [7:0]            port_a_in,                   // Pins A
    input wire logic [7:0]            port_b_in,                   // Pins B
    input wire logic [7:0]            port_c_in,                   // Pins C
    input wire logic                  periodic_irq_pending,        // Pending
    input wire gpabc_pin_drive_type   timer_drive,                 // Timer drive
    input wire gpabc_pin_drive_type   lcd_drive_b,                 // LCD drive B
    input wire gpabc_pin_drive_type   lcd_drive_c,                 // LCD drive C
    input wire gpabc_pin_drive_type   port_a_pins,                 // Drive A
    input wire gpabc_pin_drive_type   port_b_pins,                 // Drive B
    input wire gpabc_pin_drive_type   port_c_pins,                 // Drive C
    input wire logic [7:0]            port_b_high_sink,            // Sink
    input wire logic [7:0]            port_b_analog,               // Analog
    input wire logic [7:0]            timer_capture_in,            // Capture
    input wire logic                  periodic_irq_external_clock, // Ext clock
    input wire logic [3:0]            keyboard_interrupt_input,    // Key inputs
    input wire logic [1:0]            periodic_irq_clock_source    // Source
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_dir_a_wr;
        bus_req.wr && bus_req.addr == GPABC_ADDR_PORT_A_DIR ##1 !bus_req.wr;
    endsequence
    sequence s_adc_pb1;
        (mod_ctrl.adc_enable && mod_ctrl.analog_channel_select == GPABC_ADC_CH_PB1) [*2];
    endsequence
    dir_enable_a: assert property (s_dir_a_wr ##1 $stable(mod_ctrl) |->
        port_a_pins.oe == ($past(bus_req.wdata, 2) & ~{4'h0, mod_ctrl.keyboard_interrupt_enable}))
        else $error("port A enables differ from direction write");
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> port_a_pins.oe == 8'h00 &&
        port_b_pins.oe == 8'h00 && port_c_pins.oe == 8'h00 && port_b_high_sink == 8'h00)
        else $error("pin enables not cleared by reset");
    dir_readback_a: assert property (bus_req.wr && bus_req.addr == GPABC_ADDR_PORT_B_DIR ##1
        bus_req.rd && bus_req.addr == GPABC_ADDR_PORT_B_DIR |=> bus_rdata == $past(bus_req.wdata, 2))
        else $error("direction read back differs");
    rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data outside read answer");
    sink_needs_out_a: assert property (
        (port_b_high_sink & ~(port_b_pins.oe & GPABC_HD_DRIVE_MASK)) == 8'h00)
        else $error("high sink on a pin that is not an output");
    clk_source_a: assert property ((periodic_irq_clock_source != GPABC_CLKS_EXTERNAL) [*2]
        |-> !periodic_irq_external_clock) else $error("external clock passed while not selected");
    adc_claim_a: assert property (s_adc_pb1 |-> port_b_analog == 8'h02 && !port_b_pins.oe[1])
        else $error("analog claim of pin B1 missing");
    lcd_port_b_a: assert property ((mod_ctrl.lcd_module_enable && $stable(lcd_drive_b)) [*2]
        |-> port_b_pins.oe[7:6] == lcd_drive_b.oe[7:6] && port_b_pins.out[7:6] == lcd_drive_b.out[7:6])
        else $error("frontplane drive on B7:6 missing");
    timer_claim_a: assert property (mod_ctrl.timer1_ch0_edge_level_select != 2'b00 &&
        $stable(mod_ctrl) && $stable(timer_drive) |-> port_b_pins.oe[2] == timer_drive.oe[2])
        else $error("timer claim of pin B2 missing");
    key_mask_a: assert property ($stable(mod_ctrl) |->
        (port_a_pins.oe[3:0] & mod_ctrl.keyboard_interrupt_enable) == 4'h0)
        else $error("key input pin still driven");
endmodule : gpabc_ports_sva
bind gpabc_ports gpabc_ports_sva u_sva (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .mod_ctrl(mod_ctrl), .port_a_in(port_a_in), .port_b_in(port_b_in),
    .port_c_in(port_c_in), .periodic_irq_pending(periodic_irq_pending), .timer_drive(timer_drive),
    .lcd_drive_b(lcd_drive_b), .lcd_drive_c(lcd_drive_c), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .port_c_pins(port_c_pins), .port_b_high_sink(port_b_high_sink),
    .port_b_analog(port_b_analog), .timer_capture_in(timer_capture_in),
    .periodic_irq_external_clock(periodic_irq_external_clock),
    .keyboard_interrupt_input(keyboard_interrupt_input),
    .periodic_irq_clock_source(periodic_irq_clock_source));
`default_nettype wire

// file: test/gpabc_board.sv
// Purpose: Board model of the port pins
// Assumes: Undriven pins rest at a level set by the bench
// Notes:   Driven pins read back what the device drives
`timescale 1ns/1ps
`default_nettype none
module gpabc_board
    import gpabc_pkg::*;
(
    input  wire gpabc_pin_drive_type a_pins, // Device drive A
    input  wire gpabc_pin_drive_type b_pins, // Device drive B
    input  wire gpabc_pin_drive_type c_pins, // Device drive C
    input  wire logic [7:0]          a_lvl,  // Board level A
    input  wire logic [7:0]          b_lvl,  // Board level B
    input  wire logic [7:0]          c_lvl,  // Board level C
    output logic [7:0]               a_in,   // Pin level A
    output logic [7:0]               b_in,   // Pin level B
    output logic [7:0]               c_in    // Pin level C
);
    assign a_in = (a_pins.oe & a_pins.out) | (~a_pins.oe & a_lvl);
    assign b_in = (b_pins.oe & b_pins.out) | (~b_pins.oe & b_lvl);
    assign c_in = (c_pins.oe & c_pins.out) | (~c_pins.oe & c_lvl);
endmodule : gpabc_board
`default_nettype wire

// file: test/gpabc_ports_tb_top.sv
// Purpose: Register-level bench for gpabc_ports
// Assumes: One-cycle strobes, read data in the next cycle
// Notes:   Expected values built from fixed stimulus
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module gpabc_ports_tb_top
    import gpabc_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  pend = 1'b0;
    gpabc_bus_req_type     bus_req = '0;
    gpabc_module_ctrl_type mc = '0;
    gpabc_pin_drive_type   td = '0, lb = '0, lc = '0, pa, pb, pc;
    logic [7:0]            ea = 8'h3C, eb = 8'h3C, ec = 8'h3C;
    logic [7:0]            ia, ib, ic, hs, an, tci, rdata, e;
    logic                  pec;
    logic [3:0]            kin;
    logic [1:0]            pcs;
    int                    bad_count = 0;
    int                    comparisons = 0;
    gpabc_ports u_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(rdata),
        .mod_ctrl(mc), .port_a_in(ia), .port_b_in(ib), .port_c_in(ic), .periodic_irq_pending(pend),
        .timer_drive(td), .lcd_drive_b(lb), .lcd_drive_c(lc), .port_a_pins(pa), .port_b_pins(pb),
        .port_c_pins(pc), .port_b_high_sink(hs), .port_b_analog(an), .timer_capture_in(tci),
        .periodic_irq_external_clock(pec), .keyboard_interrupt_input(kin),
        .periodic_irq_clock_source(pcs));
    gpabc_board u_board (.a_pins(pa), .b_pins(pb), .c_pins(pc), .a_lvl(ea), .b_lvl(eb),
        .c_lvl(ec), .a_in(ia), .b_in(ib), .c_in(ic));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= {a, d, 2'b10};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        bus_req <= {a, 8'h00, 2'b01};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 `CHK(rdata, x)
    endtask : rdchk
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask : settle
    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int p = 0; p < 3; p++) rdchk(8'(p + 4), GPABC_DIR_RESET);
        rdchk(8'h03, 8'h00);
        wr(GPABC_ADDR_PORT_A_DATA, 8'h5A);
        wr(GPABC_ADDR_PORT_A_DIR, 8'h3C);
        @(posedge clk) sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(GPABC_ADDR_PORT_A_DIR, GPABC_DIR_RESET);
        wr(GPABC_ADDR_PORT_A_DIR, 8'hFF);
        settle();
        `CHK(pa, {8'h5A, 8'hFF})
        @(posedge clk) bus_req <= {GPABC_ADDR_PORT_B_DIR, 8'hA6, 2'b10};
        rdchk(GPABC_ADDR_PORT_B_DIR, 8'hA6);
        for (int p = 0; p < 3; p++) begin
            wr(8'(p), 8'hA5);
            wr(8'(p + 4), 8'h0F);
            wr(8'(p), 8'hFF);
            settle();
            e = (p == 0) ? pa.oe : (p == 1) ? pb.oe : pc.oe;
            `CHK(e, 8'h0F)
            rdchk(8'(p), 8'h3F);
            wr(8'(p + 4), 8'hFF);
            rdchk(8'(p), 8'hFF);
            wr(8'(p + 4), 8'h00);
        end
        wr(GPABC_ADDR_PORT_B_DIR, 8'h08);
        wr(GPABC_ADDR_HIGH_DRIVE, 8'hFD);
        pend <= 1'b1;
        eb <= 8'h04;
        settle();
        `CHK({hs, pcs, pec}, {8'h08, GPABC_CLKS_EXTERNAL, 1'b1})
        rdchk(GPABC_ADDR_HIGH_DRIVE, 8'hBD);
        wr(GPABC_ADDR_HIGH_DRIVE, 8'h3C);
        settle();
        `CHK({hs, pec}, {8'h08, 1'b0})
        wr(GPABC_ADDR_PORT_B_DIR, 8'h00);
        mc <= '{adc_enable: 1'b1, analog_channel_select: GPABC_ADC_CH_PB1,
            timer1_ch0_edge_level_select: 2'b01, timer1_ch1_edge_level_select: 2'b10,
            timer2_ch0_edge_level_select: 2'b11, timer2_ch1_edge_level_select: 2'b01,
            lcd_module_enable: 1'b1, default: '0};
        td <= '{out: 8'h28, oe: 8'h3C};
        lb <= '{out: 8'h40, oe: 8'hC0};
        lc <= '{out: 8'h15, oe: 8'h3F};
        settle();
        `CHK({pb.oe, pb.out & 8'hFC, an}, {8'hFC, 8'h68, 8'h02})
        `CHK(tci & 8'h3C, 8'h28)
        @(posedge clk) mc.analog_channel_select <= GPABC_ADC_CH_PB0;
        mc.portc_upper_lcd_enable <= 1'b1;
        settle();
        `CHK({an, pc.oe, pc.out & 8'h30}, {8'h01, 8'h30, 8'h10})
        @(posedge clk) mc.portc_lower_lcd_enable <= 1'b1;
        settle();
        `CHK({pc.oe, pc.out & 8'h3F}, {8'h3F, 8'h15})
        @(posedge clk) mc.lcd_module_enable <= 1'b0;
        mc.keyboard_interrupt_enable <= 4'hF;
        ea <= 8'h05;
        wr(GPABC_ADDR_PORT_A_DIR, 8'hFF);
        settle();
        `CHK({pc.oe, pb.oe & 8'hC0}, 16'h0000)
        `CHK({pa.oe, kin}, {8'hF0, 4'h5})
        end_of_test();
    end
endmodule : gpabc_ports_tb_top
`default_nettype wire
